// [rtl/hpes_cfg.svh]
// Purpose: Named constants for the host port endian swap block
// Assumes: Internal words are 32-bit big-endian, host bus 16 lines
// Notes: Definitions only
`ifndef HPES_CFG_SVH
`define HPES_CFG_SVH

// Widths
`define HPES_WORD_W     32
`define HPES_BYTE_W     8
`define HPES_HOST_W     16
`define HPES_BYTES      4
`define HPES_QAW_DEF    5

// Upper and lower host byte lanes
`define HPES_HI_LANE    15:8
`define HPES_LO_LANE    7:0

// Positions in the synchronised mode pin vector
`define HPES_PIN_N      5
`define HPES_PIN_LE     0
`define HPES_PIN_INV    1
`define HPES_PIN_W8     2
`define HPES_PIN_SZ1    3
`define HPES_PIN_GLUE   4

// Low address bit patterns
`define HPES_BYTE_MIRROR 2'h3
`define HPES_WORD_MIRROR 2'h2
`define HPES_LO_OF_WORD  2'h1

// Reset values and the zero byte for disabled lanes
`define HPES_PIN_RST    5'h00
`define HPES_VALID_NONE 4'h0
`define HPES_SIZE_RST   2'h0
`define HPES_WORD_RST   32'h0000_0000
`define HPES_RDATA_RST  16'h0000
`define HPES_BYTE_ZERO  8'h00

`endif

// [rtl/hpes_pkg.sv]
// Purpose: Types shared by the host port endian swap files
// Assumes: Constants come from hpes_cfg.svh
// Notes: Nothing here is imported; users write hpes_pkg::name
package hpes_pkg;

  // Where each host lane lands inside the big-endian quadlet
  typedef struct packed {
    logic [1:0] hi_idx;
    logic [1:0] lo_idx;
    logic       hi_en;
    logic       lo_en;
  } hpes_lane_t;

endpackage

// [rtl/hpes_quad_mem.sv]
// Purpose: Quadlet store for register space and queue words
// Assumes: Whole quadlets are written; reads pick two byte lanes
// Notes: Read data come out of a register, one cycle after re
`include "hpes_cfg.svh"
module hpes_quad_mem #(
  parameter int QAW = `HPES_QAW_DEF
) (
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    rst,
  // Write port
  input  wire logic                    we,
  input  wire logic [QAW-1:0]          waddr,
  input  wire logic [`HPES_WORD_W-1:0] wdata,
  // Read port with lane selection
  input  wire logic                    re,
  input  wire logic [QAW-1:0]          raddr,
  input  wire logic [1:0]              hi_idx,
  input  wire logic [1:0]              lo_idx,
  input  wire logic                    hi_en,
  input  wire logic                    lo_en,
  output logic      [`HPES_HOST_W-1:0] rdata_q
);

  logic [`HPES_WORD_W-1:0] mem [0:(1<<QAW)-1];
  logic [`HPES_WORD_W-1:0] rword;
  logic [`HPES_BYTE_W-1:0] rbyte [0:`HPES_BYTES-1];
  logic [`HPES_BYTE_W-1:0] hi_byte;
  logic [`HPES_BYTE_W-1:0] lo_byte;

  assign rword = mem[raddr];

  // Byte 0 is the most significant byte of the quadlet
  for (genvar i = 0; i < `HPES_BYTES; i++) begin : g_byte
    assign rbyte[i] =
      rword[`HPES_WORD_W-1-`HPES_BYTE_W*i -: `HPES_BYTE_W];
  end

  // Unused lane reads as zeros so a narrow bus sees a quiet upper half
  assign hi_byte = hi_en ? rbyte[hi_idx] : `HPES_BYTE_ZERO;
  assign lo_byte = lo_en ? rbyte[lo_idx] : `HPES_BYTE_ZERO;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_q <= `HPES_RDATA_RST;
    end else if (re) begin
      rdata_q <= {hi_byte, lo_byte};
    end
  end

endmodule // hpes_quad_mem

// [rtl/hpes_top.sv]
// Purpose: Byte-lane and address swapping on an 8/16-bit host port
// Assumes: Host strobes are on MCLK; mode pins are asynchronous
// Notes: Writes stack into a quadlet, reads unstack lanes from it
`include "hpes_cfg.svh"
module hpes_top #(
  parameter int QAW = `HPES_QAW_DEF
) (
  // Clock and reset
  input  wire logic                    MCLK,
  input  wire logic                    SYS_RST,
  // Host access port
  input  wire logic [QAW+1:0]          HOST_ADDR,
  input  wire logic [`HPES_HOST_W-1:0] HOST_WDATA,
  input  wire logic                    HOST_WR,
  input  wire logic                    HOST_RD,
  output logic      [`HPES_HOST_W-1:0] HOST_RDATA,
  // Status
  output logic                         HOST_SIZE_ERR,
  output logic                         HOST_STACK_PENDING,
  // Static mode pins
  input  wire logic                    LITTLE_ENDIAN_SELECT,
  input  wire logic                    DATA_INVARIANCE_SELECT,
  input  wire logic                    BUS_WIDTH_SIZE0,
  input  wire logic                    ACCESS_MODE_SIZE1,
  input  wire logic                    GLUELESS_PROCESSOR_MODE
);

  // Lane placement for one host access
  function automatic hpes_pkg::hpes_lane_t lane_map(
    input logic [1:0] a,
    input logic       le,
    input logic       inv,
    input logic       w8,
    input logic       glue
  );
    hpes_pkg::hpes_lane_t m;
    logic                 wide8;
    logic                 swap;
    logic [1:0]           word_a;
    logic [1:0]           word_x;
    wide8  = w8 & ~glue;
    swap   = le & ~glue;
    word_a = a & `HPES_WORD_MIRROR;
    word_x = (a ^ `HPES_WORD_MIRROR) & `HPES_WORD_MIRROR;
    m.hi_en = ~wide8;
    m.lo_en = 1'b1;
    if (!swap) begin
      m.hi_idx = word_a;
      m.lo_idx = wide8 ? a : (word_a | `HPES_LO_OF_WORD);
    end else if (inv) begin
      m.hi_idx = word_x;
      m.lo_idx = wide8 ? (a ^ `HPES_BYTE_MIRROR)
                       : (word_x | `HPES_LO_OF_WORD);
    end else begin
      m.hi_idx = word_a | `HPES_LO_OF_WORD;
      m.lo_idx = wide8 ? a : word_a;
    end
    return m;
  endfunction

  // Mode pin synchroniser; the first stage feeds only the second
  logic [`HPES_PIN_N-1:0] pin_raw;
  logic [`HPES_PIN_N-1:0] pin_meta_q;
  logic [`HPES_PIN_N-1:0] pin_q;

  assign pin_raw[`HPES_PIN_LE]   = LITTLE_ENDIAN_SELECT;
  assign pin_raw[`HPES_PIN_INV]  = DATA_INVARIANCE_SELECT;
  assign pin_raw[`HPES_PIN_W8]   = BUS_WIDTH_SIZE0;
  assign pin_raw[`HPES_PIN_SZ1]  = ACCESS_MODE_SIZE1;
  assign pin_raw[`HPES_PIN_GLUE] = GLUELESS_PROCESSOR_MODE;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      pin_meta_q <= `HPES_PIN_RST;
      pin_q      <= `HPES_PIN_RST;
    end else begin
      pin_meta_q <= pin_raw;
      pin_q      <= pin_meta_q;
    end
  end

  // Settled mode pins, named once for the decoders below
  logic mode_le;
  logic mode_inv;
  logic mode_w8;
  logic mode_sz1;
  logic mode_glue;

  // Only the second stage is read, never the metastable first one
  assign mode_le   = pin_q[`HPES_PIN_LE];
  assign mode_inv  = pin_q[`HPES_PIN_INV];
  assign mode_w8   = pin_q[`HPES_PIN_W8];
  assign mode_sz1  = pin_q[`HPES_PIN_SZ1];
  assign mode_glue = pin_q[`HPES_PIN_GLUE];

  // Decoding shared by the write and read paths
  hpes_pkg::hpes_lane_t lane;
  logic [1:0]           byte_addr;
  logic [QAW-1:0]       quad_addr;
  logic [1:0]           size_now;

  // Only the low two bits take part in any swap
  assign byte_addr = HOST_ADDR[1:0];
  assign quad_addr = HOST_ADDR[QAW+1:2];
  // Glueless mode has no byte form, so the function overrules the width
  assign size_now  = {mode_sz1, mode_w8};
  assign lane      = lane_map(byte_addr,
                              mode_le,
                              mode_inv,
                              mode_w8,
                              mode_glue);

  // Write stacking register
  logic [`HPES_WORD_W-1:0] stack_q;
  logic [`HPES_WORD_W-1:0] stack_d;
  logic [`HPES_BYTES-1:0]  valid_q;
  logic [`HPES_BYTES-1:0]  valid_d;
  logic [`HPES_BYTES-1:0]  base_valid;
  logic [`HPES_BYTES-1:0]  merged_valid;
  logic [`HPES_BYTES-1:0]  hit_hi;
  logic [`HPES_BYTES-1:0]  hit_lo;
  logic [QAW-1:0]          stack_addr_q;
  logic [QAW-1:0]          stack_addr_d;
  logic [1:0]              size_q;
  logic [1:0]              size_d;
  logic                    same_quad;
  logic                    commit;
  logic                    size_err_q;
  logic                    size_err_d;
  logic                    pending_q;
  logic                    pending_d;

  // A write to another quadlet drops the partial stack and starts over
  assign same_quad  = (quad_addr == stack_addr_q) && (valid_q != '0);
  assign base_valid = same_quad ? valid_q : `HPES_VALID_NONE;

  for (genvar i = 0; i < `HPES_BYTES; i++) begin : g_stack
    assign hit_hi[i] = HOST_WR && lane.hi_en && (lane.hi_idx == 2'(i));
    assign hit_lo[i] = HOST_WR && lane.lo_en && (lane.lo_idx == 2'(i));
    assign merged_valid[i] = base_valid[i] | hit_hi[i] | hit_lo[i];
    assign stack_d[`HPES_WORD_W-1-`HPES_BYTE_W*i -: `HPES_BYTE_W] =
      hit_hi[i] ? HOST_WDATA[`HPES_HI_LANE] :
      hit_lo[i] ? HOST_WDATA[`HPES_LO_LANE] :
      stack_q[`HPES_WORD_W-1-`HPES_BYTE_W*i -: `HPES_BYTE_W];
  end

  // The quadlet is stored only once all four bytes have arrived
  assign commit       = HOST_WR && (&merged_valid);
  assign valid_d      = !HOST_WR ? valid_q :
                        commit   ? `HPES_VALID_NONE : merged_valid;
  assign stack_addr_d = HOST_WR ? quad_addr : stack_addr_q;
  assign size_d       = (HOST_WR && !same_quad) ? size_now : size_q;
  assign pending_d    = (valid_d != `HPES_VALID_NONE);

  // Size pins moving inside a stacked access are flagged; the write still uses the new width
  assign size_err_d   = HOST_WR && same_quad && (size_now != size_q);

  // Stacked bytes and the quadlet they belong to
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      stack_q      <= `HPES_WORD_RST;
      stack_addr_q <= '0;
    end else begin
      stack_q      <= stack_d;
      stack_addr_q <= stack_addr_d;
    end
  end

  // Byte arrival mask and the size the stack started with
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      valid_q <= `HPES_VALID_NONE;
      size_q  <= `HPES_SIZE_RST;
    end else begin
      valid_q <= valid_d;
      size_q  <= size_d;
    end
  end

  // Status flags; the error is a one-cycle pulse, never sticky
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      size_err_q <= 1'b0;
      pending_q  <= 1'b0;
    end else begin
      size_err_q <= size_err_d;
      pending_q  <= pending_d;
    end
  end

  // Reads see only committed quadlets; a half-stacked word stays hidden
  hpes_quad_mem #(
    .QAW (QAW)
  ) u_mem (
    .clk     (MCLK),
    .rst     (SYS_RST),
    .we      (commit),
    .waddr   (quad_addr),
    .wdata   (stack_d),
    .re      (HOST_RD),
    .raddr   (quad_addr),
    .hi_idx  (lane.hi_idx),
    .lo_idx  (lane.lo_idx),
    .hi_en   (lane.hi_en),
    .lo_en   (lane.lo_en),
    .rdata_q (HOST_RDATA)
  );

  assign HOST_SIZE_ERR      = size_err_q;
  assign HOST_STACK_PENDING = pending_q;

endmodule // hpes_top

// [dv/hpes_top_checker.sv]
// Purpose: Port assertions for hpes_top
// Assumes: Mode pins only move between accesses
// Notes: Pin-dependent checks wait until the pins have settled
module hpes_top_checker #(
  parameter int QAW = 5
) (
  // Clock and reset
  input wire logic           MCLK,
  input wire logic           SYS_RST,
  // Host port
  input wire logic [QAW+1:0] HOST_ADDR,
  input wire logic [15:0]    HOST_WDATA,
  input wire logic           HOST_WR,
  input wire logic           HOST_RD,
  input wire logic [15:0]    HOST_RDATA,
  input wire logic           HOST_SIZE_ERR,
  input wire logic           HOST_STACK_PENDING,
  // Mode pins
  input wire logic           LITTLE_ENDIAN_SELECT,
  input wire logic           DATA_INVARIANCE_SELECT,
  input wire logic           BUS_WIDTH_SIZE0,
  input wire logic           ACCESS_MODE_SIZE1,
  input wire logic           GLUELESS_PROCESSOR_MODE
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] p1_q;
  logic [4:0] p2_q;
  wire  [4:0] pins = {GLUELESS_PROCESSOR_MODE, ACCESS_MODE_SIZE1,
                      BUS_WIDTH_SIZE0, DATA_INVARIANCE_SELECT,
                      LITTLE_ENDIAN_SELECT};
  // Pins pass two sync flops, so judge only after two quiet edges
  wire settled = (pins == p1_q) && (p1_q == p2_q);
  wire w8 = settled && BUS_WIDTH_SIZE0 && !GLUELESS_PROCESSOR_MODE;
  wire glue = settled && GLUELESS_PROCESSOR_MODE;
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      p1_q <= 5'h00;
      p2_q <= 5'h00;
    end else begin
      p1_q <= pins;
      p2_q <= p1_q;
    end
  end
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  AST_UPPER_ZERO: assert property (
    HOST_RD && w8 |=> HOST_RDATA[15:8] == 8'h00)
    else $error("upper lane not zero on byte bus");
  AST_RDATA_HOLD: assert property (
    !HOST_RD |=> $stable(HOST_RDATA))
    else $error("read data moved without a read");
  AST_ERR_AFTER_WR: assert property (
    HOST_SIZE_ERR |-> $past(HOST_WR))
    else $error("size error without a write");
  AST_ERR_MID_STACK: assert property (
    HOST_SIZE_ERR |-> $past(HOST_STACK_PENDING))
    else $error("size error outside a stack");
  AST_PEND_RISE: assert property (
    $rose(HOST_STACK_PENDING) |-> $past(HOST_WR))
    else $error("stack started without a write");
  AST_PEND_FALL: assert property (
    $fell(HOST_STACK_PENDING) |-> $past(HOST_WR))
    else $error("stack ended without a write");
  AST_BYTE_STACKS: assert property (
    HOST_WR && w8 && !HOST_STACK_PENDING |=> HOST_STACK_PENDING)
    else $error("byte write did not start a stack");
  AST_GLUE_WORDS: assert property (
    glue && HOST_WR && !HOST_STACK_PENDING && HOST_ADDR[1:0] == 2'h0
    ##1 glue && HOST_WR && HOST_ADDR[1:0] == 2'h2
    && HOST_ADDR[QAW+1:2] == $past(HOST_ADDR[QAW+1:2])
    |=> !HOST_STACK_PENDING)
    else $error("two words did not fill the quadlet");
  COV_SIZE_ERR: cover property (HOST_SIZE_ERR);
  COV_GLUE_PAIR: cover property (glue && HOST_WR ##1 HOST_WR);
  COV_COMMIT: cover property ($fell(HOST_STACK_PENDING));
  COV_BYTE_READ: cover property (HOST_RD && w8);
endmodule // hpes_top_checker

bind hpes_top hpes_top_checker #(.QAW(QAW)) u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .HOST_ADDR(HOST_ADDR),
  .HOST_WDATA(HOST_WDATA), .HOST_WR(HOST_WR), .HOST_RD(HOST_RD),
  .HOST_RDATA(HOST_RDATA), .HOST_SIZE_ERR(HOST_SIZE_ERR),
  .HOST_STACK_PENDING(HOST_STACK_PENDING),
  .LITTLE_ENDIAN_SELECT(LITTLE_ENDIAN_SELECT),
  .DATA_INVARIANCE_SELECT(DATA_INVARIANCE_SELECT),
  .BUS_WIDTH_SIZE0(BUS_WIDTH_SIZE0), .ACCESS_MODE_SIZE1(ACCESS_MODE_SIZE1),
  .GLUELESS_PROCESSOR_MODE(GLUELESS_PROCESSOR_MODE));

// [dv/hpes_host_model.sv]
// Purpose: Host processor model driving the host port
// Assumes: One strobe per access, data back one cycle later
// Notes: Released data lines show the inverse of the last value
module hpes_host_model #(
  parameter int QAW = 5
) (
  // Clock
  input  wire logic           clk,
  // Host bus
  output logic      [QAW+1:0] addr,
  output logic      [15:0]    wdata,
  output logic                wr,
  output logic                rd,
  input  wire logic [15:0]    rdata,
  // Mode pins
  output logic                le,
  output logic                inv,
  output logic                w8,
  output logic                sz1,
  output logic                glue
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr = '0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    {glue, sz1, w8, inv, le} = 5'h00;
  end
  // Pins only move between accesses and settle before the next one
  task automatic mode(input logic [4:0] p);
    @(posedge clk);
    {glue, sz1, w8, inv, le} <= p;
    repeat (3) @(posedge clk);
  endtask
  task automatic wr_cyc(input logic [QAW+1:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask
  // Two writes on consecutive edges, strobe held high between them
  task automatic wr_pair(input logic [QAW+1:0] a0, input logic [15:0] d0,
                         input logic [QAW+1:0] a1, input logic [15:0] d1);
    @(posedge clk);
    addr <= a0;
    wdata <= d0;
    wr <= 1'b1;
    @(posedge clk);
    addr <= a1;
    wdata <= d1;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d1;
  endtask
  task automatic rd_cyc(input logic [QAW+1:0] a, output logic [15:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule // hpes_host_model

// [dv/test_host_port_endian_swap.sv]
// Purpose: Self-checking bench for hpes_top lane mapping
// Assumes: Memory is read only where written first
// Notes: Pins are {glue, sz1, w8, inv, le} in mode calls
module test_host_port_endian_swap;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int QAW = 5;
  logic           mclk = 1'b0;
  logic           sys_rst = 1'b1;
  logic [QAW+1:0] addr;
  logic [15:0]    wdata, rdata;
  logic           wr, rd, size_err, pend;
  logic           le, inv, w8, sz1, glue;
  int             errors = 0;
  int             n_checks = 0;
  always #5 mclk = ~mclk;
  hpes_host_model #(.QAW(QAW)) u_host (.clk(mclk), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .le(le), .inv(inv),
    .w8(w8), .sz1(sz1), .glue(glue));
  hpes_top #(.QAW(QAW)) u_dut (.MCLK(mclk), .SYS_RST(sys_rst),
    .HOST_ADDR(addr), .HOST_WDATA(wdata), .HOST_WR(wr), .HOST_RD(rd),
    .HOST_RDATA(rdata), .HOST_SIZE_ERR(size_err),
    .HOST_STACK_PENDING(pend), .LITTLE_ENDIAN_SELECT(le),
    .DATA_INVARIANCE_SELECT(inv), .BUS_WIDTH_SIZE0(w8),
    .ACCESS_MODE_SIZE1(sz1), .GLUELESS_PROCESSOR_MODE(glue));
  task automatic chk(input string what, input logic [15:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rc(input logic [QAW+1:0] a, input logic [15:0] exp);
    logic [15:0] d;
    u_host.rd_cyc(a, d);
    chk("HOST_RDATA", d, exp);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // A hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    print_verdict();
  end
  initial begin
    repeat (3) @(posedge mclk);
    sys_rst <= 1'b0;
    u_host.mode(5'h00);
    u_host.wr_cyc(7'h04, 16'h1122);
    u_host.wr_cyc(7'h06, 16'h3344);
    rc(7'h04, 16'h1122);
    rc(7'h06, 16'h3344);
    u_host.mode(5'h04);
    for (int i = 0; i < 4; i++) begin
      rc(7'(4 + i), {8'h00, 8'(8'h11 * (i + 1))});
    end
    $display("test big endian done");
    u_host.mode(5'h03);
    rc(7'h04, 16'h3344);
    rc(7'h06, 16'h1122);
    u_host.mode(5'h07);
    rc(7'h04, 16'h0044);
    rc(7'h07, 16'h0011);
    u_host.mode(5'h05);
    rc(7'h05, 16'h0022);
    u_host.mode(5'h01);
    rc(7'h04, 16'h2211);
    u_host.wr_cyc(7'h08, 16'haabb);
    u_host.wr_cyc(7'h0a, 16'hccdd);
    rc(7'h08, 16'haabb);
    u_host.mode(5'h00);
    rc(7'h08, 16'hbbaa);
    rc(7'h0a, 16'hddcc);
    $display("test little endian done");
    u_host.mode(5'h17);
    rc(7'h04, 16'h1122);
    u_host.wr_pair(7'h0c, 16'h5566, 7'h0e, 16'h7788);
    rc(7'h0e, 16'h7788);
    rc(7'h0c, 16'h5566);
    $display("test glueless done");
    u_host.mode(5'h04);
    u_host.wr_cyc(7'h10, 16'h0099);
    #1 chk("HOST_STACK_PENDING", {15'h0000, pend}, 16'h0001);
    u_host.mode(5'h00);
    u_host.wr_cyc(7'h12, 16'h0088);
    #1 chk("HOST_SIZE_ERR", {15'h0000, size_err}, 16'h0001);
    u_host.mode(5'h08);
    u_host.wr_cyc(7'h10, 16'h1234);
    #1 chk("HOST_SIZE_ERR", {15'h0000, size_err}, 16'h0001);
    chk("HOST_STACK_PENDING", {15'h0000, pend}, 16'h0000);
    rc(7'h10, 16'h1234);
    rc(7'h12, 16'h0088);
    $display("test stacking done");
    print_verdict();
  end
endmodule // test_host_port_endian_swap
